// *** hw/codec_ctl_pkg.sv ***
// package for the dual voice codec path control and microphone mute block
// assumes a single 250 MHz system clock and a plain register port on the host side
package codec_ctl_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] OFS_XPOINT = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h04;
  localparam logic [7:0] OFS_GAIN   = 8'h08;
  localparam logic [7:0] OFS_BIAS   = 8'h0C;
  localparam logic [7:0] OFS_MODE   = 8'h10;
  localparam logic [7:0] OFS_PCM    = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // register widths
  localparam int XPT_W  = 11;
  localparam int EN_W   = 3;
  localparam int GAIN_W = 12;
  localparam int BIAS_W = 4;
  localparam int MODE_W = 8;
  localparam int PCM_W  = 23;

  // cross-point fields
  localparam int XPT_CONNECT = 0;   // two codec connect bits
  localparam int XPT_EAR0    = 2;   // codec 0 earpiece select
  localparam int XPT_EAR1    = 4;   // codec 1 earpiece select
  localparam int XPT_MIC0    = 6;   // codec 0 microphone select
  localparam int XPT_MIC1    = 8;   // codec 1 microphone select
  localparam int XPT_AUX     = 10;  // auxiliary tone select

  // enable fields
  localparam int EN_TX   = 0;       // two tx analog channel enables
  localparam int EN_VREF = 2;       // reference power-up

  // gain fields
  localparam int GAIN_SIDE      = 0;  // sidetone code, -39 dB + 3 dB per step
  localparam int GAIN_SIDE_MUTE = 4;
  localparam int GAIN_RX0       = 8;  // analog rx gain of interface 0 and aux tone

  // mode fields
  localparam int MODE_SOFT  = 0;    // four direct mic mutes
  localparam int MODE_BEHAV = 4;    // two 2-bit mute behaviours

  // pcm fields
  localparam int PCM_FMT    = 0;
  localparam int PCM_LAW    = 2;
  localparam int PCM_DMW    = 4;
  localparam int PCM_SLOT0  = 8;
  localparam int PCM_SLOT1  = 13;
  localparam int PCM_SLOTST = 18;

  // reset values
  localparam logic [XPT_W-1:0]  XPT_RST  = 11'h000;
  localparam logic [EN_W-1:0]   EN_RST   = 3'h0;
  localparam logic [GAIN_W-1:0] GAIN_RST = 12'h000;
  localparam logic [BIAS_W-1:0] BIAS_RST = 4'h0;
  localparam logic [MODE_W-1:0] MODE_RST = 8'h00;
  localparam logic [PCM_W-1:0]  PCM_RST  = 23'h000000;

  // calibration length in frame-alignment pulses
  localparam logic [7:0] CAL_PULSES = 8'h80;

  typedef enum logic [1:0] {FMT_ST = 2'b00, FMT_GCI = 2'b01, FMT_SSI = 2'b10} pcm_fmt_t;
  typedef enum logic [1:0] {LAW_A = 2'b00, LAW_U = 2'b01, LAW_LIN = 2'b10} pcm_law_t;
  typedef enum logic [1:0] {
    MM_OPEN = 2'b00, MM_FOLLOW = 2'b01, MM_LATCH = 2'b10, MM_ALWAYS = 2'b11
  } mute_mode_t;
  typedef enum logic {MIC_OPEN = 1'b0, MIC_HELD = 1'b1} mute_st_t;
  typedef enum logic [1:0] {CAL_IDLE = 2'b00, CAL_RUN = 2'b01, CAL_DONE = 2'b10} cal_st_t;

  // digital milliwatt, phase -7/8 first
  localparam logic [0:7][7:0] DMW_ALAW = {8'h34, 8'h21, 8'h21, 8'h34,
                                          8'hB4, 8'hA1, 8'hA1, 8'hB4};
  localparam logic [0:7][7:0] DMW_ULAW = {8'h1E, 8'h0B, 8'h0B, 8'h1E,
                                          8'h9E, 8'h8B, 8'h8B, 8'h9E};
  localparam logic [0:7][15:0] DMW_LIN = {16'hDD84, 16'hAE84, 16'hAE84, 16'hDD84,
                                          16'h227C, 16'h517C, 16'h517C, 16'h227C};

endpackage : codec_ctl_pkg

// *** hw/codec_path_ctl.sv ***
// cross-point, mute, sidetone, calibration sequencing and pcm output control
// assumes pin inputs are asynchronous and the register master runs on clk_sys
//
// Local design decisions: the address map and the address-and-strobe port.

module codec_path_ctl (
  input  wire logic                                clk_sys,
  input  wire logic                                rst_n,
  input  wire logic [codec_ctl_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [codec_ctl_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                                reg_wr,
  input  wire logic                                reg_rd,
  output logic      [codec_ctl_pkg::DATA_W-1:0]    reg_rdata,
  input  wire logic [1:0]                          mic_detect_input,
  input  wire logic [1:0]                          mic_present_input,
  input  wire logic                                pcm_frame_alignment,
  input  wire logic                                pcm_bit_clk,
  input  wire logic [15:0]                         tx_word0,
  input  wire logic [15:0]                         tx_word1,
  output logic                                     pcm_serial_out,
  output logic                                     pcm_serial_oe,
  output logic [3:0]                               ear_from_codec0,
  output logic [3:0]                               ear_from_codec1,
  output logic [3:0]                               mic_to_codec0,
  output logic [3:0]                               mic_to_codec1,
  output logic                                     aux_tone_input_sel,
  output logic [3:0]                               loudspeaker_outputs_gain,
  output logic [3:0]                               sidetone_gain,
  output logic [1:0]                               sidetone_on,
  output logic [3:0]                               electret_bias_output,
  output logic [3:0]                               mic_muted,
  output logic [1:0]                               tx_analog_en,
  output logic [1:0]                               cal_active,
  output logic                                     vref_power_on
);

  // sync bit map: 0..1 detect, 2..3 presence, 4 frame, 5 bit clock
  localparam int NS = 6;
  localparam int SY_FRAME = 4;
  localparam int SY_BCLK = 5;

  typedef struct packed {
    logic [NS-1:0]                       sync1;
    logic [NS-1:0]                       sync2;
    logic [NS-1:0]                       sync3;
    logic [NS-1:0]                       filt;
    logic [NS-1:0]                       filt_d;
    logic [codec_ctl_pkg::XPT_W-1:0]     xpt_r;
    logic [codec_ctl_pkg::EN_W-1:0]      en_r;
    logic [codec_ctl_pkg::GAIN_W-1:0]    gain_r;
    logic [codec_ctl_pkg::BIAS_W-1:0]    bias_r;
    logic [codec_ctl_pkg::MODE_W-1:0]    mode_r;
    logic [codec_ctl_pkg::PCM_W-1:0]     pcm_r;
    logic [codec_ctl_pkg::DATA_W-1:0]    rdata_r;
    codec_ctl_pkg::mute_st_t [1:0]       hold_r;
    codec_ctl_pkg::cal_st_t [1:0]        cal_r;
    logic [1:0][7:0]                     cal_cnt_r;
    logic [8:0]                          bit_cnt_r;
    logic                                half_r;
    logic [2:0]                          dmw_ph_r;
    logic [3:0]                          ear0_r;
    logic [3:0]                          ear1_r;
    logic [3:0]                          mic0_r;
    logic [3:0]                          mic1_r;
    logic [3:0]                          muted_r;
    logic [1:0]                          side_r;
    logic                                pout_r;
    logic                                poe_r;
  } state_t;

  state_t q;
  state_t n;

  function automatic logic [3:0] one_hot4(input logic [1:0] s);
    one_hot4 = 4'h1 << s;
  endfunction : one_hot4

  // working signals of the combinational process
  logic [1:0]  det, det_mute, connect, fmt;
  logic        fa, fa_prev, frame_start, bclk_rise, frame_rise, lin, drive;
  logic [4:0]  byte_idx, slot0, slot1, slotst;
  logic [15:0] w0, w1, dmw_w;
  logic [7:0]  status_b, obyte;
  logic [3:0]  mic0_sel, ear0_sel;

  always_comb begin
    n = q;
    det = '0;
    det_mute = '0;
    // three-stage sync, change taken when stages two and three agree
    n.sync1 = {pcm_bit_clk, pcm_frame_alignment, mic_present_input, mic_detect_input};
    n.sync2 = q.sync1;
    n.sync3 = q.sync2;
    for (int i = 0; i < NS; i++) begin
      if (q.sync2[i] == q.sync3[i]) begin
        n.filt[i] = q.sync3[i];
      end
    end
    n.filt_d = q.filt;

    // register writes; unused upper bits are dropped
    if (reg_wr) begin
      case (reg_addr)
        codec_ctl_pkg::OFS_XPOINT: n.xpt_r  = reg_wdata[codec_ctl_pkg::XPT_W-1:0];
        codec_ctl_pkg::OFS_ENABLE: n.en_r   = reg_wdata[codec_ctl_pkg::EN_W-1:0];
        codec_ctl_pkg::OFS_GAIN:   n.gain_r = reg_wdata[codec_ctl_pkg::GAIN_W-1:0];
        codec_ctl_pkg::OFS_BIAS:   n.bias_r = reg_wdata[codec_ctl_pkg::BIAS_W-1:0];
        codec_ctl_pkg::OFS_MODE:   n.mode_r = reg_wdata[codec_ctl_pkg::MODE_W-1:0];
        codec_ctl_pkg::OFS_PCM:    n.pcm_r  = reg_wdata[codec_ctl_pkg::PCM_W-1:0];
        default: ;
      endcase
    end

    // presence only reported; raw detect and actual mute
    status_b = {q.cal_r[1] == codec_ctl_pkg::CAL_RUN, q.cal_r[0] == codec_ctl_pkg::CAL_RUN,
                q.muted_r[3:2], q.filt[1:0], q.filt[3:2]};

    // read data valid the cycle after the strobe, zero otherwise
    n.rdata_r = '0;
    if (reg_rd) begin
      case (reg_addr)
        codec_ctl_pkg::OFS_XPOINT: n.rdata_r = {21'h000000, q.xpt_r};
        codec_ctl_pkg::OFS_ENABLE: n.rdata_r = {29'h00000000, q.en_r};
        codec_ctl_pkg::OFS_GAIN:   n.rdata_r = {20'h00000, q.gain_r};
        codec_ctl_pkg::OFS_BIAS:   n.rdata_r = {28'h0000000, q.bias_r};
        codec_ctl_pkg::OFS_MODE:   n.rdata_r = {24'h000000, q.mode_r};
        codec_ctl_pkg::OFS_PCM:    n.rdata_r = {9'h000, q.pcm_r};
        codec_ctl_pkg::OFS_STATUS: n.rdata_r = {24'h000000, status_b};
        default: n.rdata_r = '0;
      endcase
    end

    // mute behaviour per monitored microphone (interfaces 2 and 3)
    for (int j = 0; j < 2; j++) begin
      det[j] = q.filt[j];
      case (q.mode_r[codec_ctl_pkg::MODE_BEHAV + 2*j +: 2])
        codec_ctl_pkg::MM_OPEN: begin
          // writing open is what releases a held mute
          n.hold_r[j] = codec_ctl_pkg::MIC_OPEN;
          det_mute[j] = 1'b0;
        end
        codec_ctl_pkg::MM_FOLLOW: det_mute[j] = det[j];
        codec_ctl_pkg::MM_LATCH: begin
          if (det[j]) begin
            n.hold_r[j] = codec_ctl_pkg::MIC_HELD;
          end
          det_mute[j] = det[j] | (q.hold_r[j] == codec_ctl_pkg::MIC_HELD);
        end
        codec_ctl_pkg::MM_ALWAYS: det_mute[j] = 1'b1;
        default: det_mute[j] = 1'b1;
      endcase
    end
    // direct software mutes; detect mute joins at once
    n.muted_r = q.mode_r[codec_ctl_pkg::MODE_SOFT +: 4] | {det_mute, 2'b00};

    // nothing routes unless the codec's connect bit is set
    connect = q.xpt_r[codec_ctl_pkg::XPT_CONNECT +: 2];
    // two-bit selects pick one of four interfaces per codec
    mic0_sel = one_hot4(q.xpt_r[codec_ctl_pkg::XPT_MIC0 +: 2]);
    ear0_sel = one_hot4(q.xpt_r[codec_ctl_pkg::XPT_EAR0 +: 2]);
    n.mic0_r = connect[0] ? (mic0_sel & ~n.muted_r) : 4'h0;
    n.mic1_r = connect[1] ? (one_hot4(q.xpt_r[codec_ctl_pkg::XPT_MIC1 +: 2]) & ~n.muted_r)
                          : 4'h0;
    n.ear0_r = connect[0] ? ear0_sel : 4'h0;
    n.ear1_r = connect[1] ? one_hot4(q.xpt_r[codec_ctl_pkg::XPT_EAR1 +: 2]) : 4'h0;
    // codec zero keeps a shared interface
    if (connect[0]) begin
      n.mic1_r = n.mic1_r & ~mic0_sel;
      n.ear1_r = n.ear1_r & ~ear0_sel;
    end
    // aux tone takes the loudspeaker driver from either codec
    if (q.xpt_r[codec_ctl_pkg::XPT_AUX]) begin
      n.ear0_r[0] = 1'b0;
      n.ear1_r[0] = 1'b0;
    end
    // sidetone follows the codec's live mic; mute bit removes it
    n.side_r[0] = connect[0] & ~q.gain_r[codec_ctl_pkg::GAIN_SIDE_MUTE] & (|n.mic0_r);
    n.side_r[1] = connect[1] & ~q.gain_r[codec_ctl_pkg::GAIN_SIDE_MUTE] & (|n.mic1_r);

    // frame and bit clock edges from the filtered pin levels
    fmt = q.pcm_r[codec_ctl_pkg::PCM_FMT +: 2];
    fa = (fmt == codec_ctl_pkg::FMT_ST) ? ~q.filt[SY_FRAME] : q.filt[SY_FRAME];
    fa_prev = (fmt == codec_ctl_pkg::FMT_ST) ? ~q.filt_d[SY_FRAME] : q.filt_d[SY_FRAME];
    frame_start = fa & ~fa_prev;
    frame_rise = q.filt[SY_FRAME] & ~q.filt_d[SY_FRAME];
    bclk_rise = q.filt[SY_BCLK] & ~q.filt_d[SY_BCLK];

    // one calibration sequencer per tx channel, frame clocked
    for (int c = 0; c < 2; c++) begin
      case (q.cal_r[c])
        codec_ctl_pkg::CAL_IDLE: begin
          n.cal_cnt_r[c] = '0;
          if (q.en_r[codec_ctl_pkg::EN_TX + c]) begin
            n.cal_r[c] = codec_ctl_pkg::CAL_RUN;
          end
        end
        codec_ctl_pkg::CAL_RUN: begin
          if (frame_rise) begin
            n.cal_cnt_r[c] = q.cal_cnt_r[c] + 8'h01;
            if (q.cal_cnt_r[c] == codec_ctl_pkg::CAL_PULSES - 8'h01) begin
              n.cal_r[c] = codec_ctl_pkg::CAL_DONE;
            end
          end
        end
        codec_ctl_pkg::CAL_DONE: n.cal_r[c] = q.cal_r[c];
        default: n.cal_r[c] = codec_ctl_pkg::CAL_IDLE;
      endcase
      // disabling the channel aborts and rearms the sequence
      if (!q.en_r[codec_ctl_pkg::EN_TX + c]) begin
        n.cal_r[c] = codec_ctl_pkg::CAL_IDLE;
      end
    end

    // bit counter; st and gci clocks run at twice the bit rate
    if (frame_start) begin
      n.bit_cnt_r = '0;
      n.half_r = 1'b0;
      n.dmw_ph_r = q.dmw_ph_r + 3'h1;
    end else if (bclk_rise && q.bit_cnt_r != 9'h1FF) begin
      if (fmt == codec_ctl_pkg::FMT_SSI || q.half_r) begin
        n.bit_cnt_r = q.bit_cnt_r + 9'h001;
      end
      n.half_r = ~q.half_r;
    end

    // milliwatt word in the selected coding
    case (q.pcm_r[codec_ctl_pkg::PCM_LAW +: 2])
      codec_ctl_pkg::LAW_A:   dmw_w = {8'h00, codec_ctl_pkg::DMW_ALAW[q.dmw_ph_r]};
      codec_ctl_pkg::LAW_U:   dmw_w = {8'h00, codec_ctl_pkg::DMW_ULAW[q.dmw_ph_r]};
      codec_ctl_pkg::LAW_LIN: dmw_w = codec_ctl_pkg::DMW_LIN[q.dmw_ph_r];
      default:                dmw_w = 16'h0000;
    endcase
    lin = q.pcm_r[codec_ctl_pkg::PCM_LAW +: 2] == codec_ctl_pkg::LAW_LIN;
    w0 = q.pcm_r[codec_ctl_pkg::PCM_DMW] ? dmw_w : tx_word0;
    w1 = q.pcm_r[codec_ctl_pkg::PCM_DMW] ? dmw_w : tx_word1;
    slot0 = q.pcm_r[codec_ctl_pkg::PCM_SLOT0 +: 5];
    slot1 = q.pcm_r[codec_ctl_pkg::PCM_SLOT1 +: 5];
    slotst = q.pcm_r[codec_ctl_pkg::PCM_SLOTST +: 5];
    byte_idx = q.bit_cnt_r[7:3];

    // slot decode, codec 0 over codec 1 over status
    drive = 1'b0;
    obyte = 8'h00;
    case (fmt)
      codec_ctl_pkg::FMT_ST: begin
        if (!q.bit_cnt_r[8]) begin
          if (byte_idx == slot0 || (lin && byte_idx == slot0 + 5'd1)) begin
            drive = 1'b1;
            obyte = (lin && byte_idx == slot0) ? w0[15:8] : w0[7:0];
          end else if (byte_idx == slot1 || (lin && byte_idx == slot1 + 5'd1)) begin
            drive = 1'b1;
            obyte = (lin && byte_idx == slot1) ? w1[15:8] : w1[7:0];
          end else if (byte_idx == slotst) begin
            drive = 1'b1;
            obyte = status_b;
          end
        end
      end
      codec_ctl_pkg::FMT_GCI: begin
        // four bytes per channel, only b1 and b2 are ever driven
        if (!q.bit_cnt_r[8]) begin
          if (byte_idx[4:2] == slot0[2:0] && (byte_idx[1:0] == 2'd0 ||
              (lin && byte_idx[1:0] == 2'd1))) begin
            drive = 1'b1;
            obyte = (lin && byte_idx[1:0] == 2'd0) ? w0[15:8] : w0[7:0];
          end else if (byte_idx[4:2] == slot1[2:0] && (byte_idx[1:0] == 2'd0 ||
                       (lin && byte_idx[1:0] == 2'd1))) begin
            drive = 1'b1;
            obyte = (lin && byte_idx[1:0] == 2'd0) ? w1[15:8] : w1[7:0];
          end else if (byte_idx[4:2] == slotst[2:0] && byte_idx[1:0] == 2'd0) begin
            drive = 1'b1;
            obyte = status_b;
          end
        end
      end
      codec_ctl_pkg::FMT_SSI: begin
        // codec 0, then codec 1, then status, only while select is high
        if (fa) begin
          if (lin) begin
            drive = byte_idx < 5'd5;
            case (byte_idx)
              5'd0:    obyte = w0[15:8];
              5'd1:    obyte = w0[7:0];
              5'd2:    obyte = w1[15:8];
              5'd3:    obyte = w1[7:0];
              default: obyte = status_b;
            endcase
          end else begin
            drive = byte_idx < 5'd3;
            case (byte_idx)
              5'd0:    obyte = w0[7:0];
              5'd1:    obyte = w1[7:0];
              default: obyte = status_b;
            endcase
          end
        end
      end
      default: drive = 1'b0;
    endcase
    n.poe_r = drive;
    n.pout_r = drive & obyte[3'd7 - q.bit_cnt_r[2:0]];
  end

  // state register, synchronous reset to constants only
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q <= '0;
      q.xpt_r <= codec_ctl_pkg::XPT_RST;
      q.en_r <= codec_ctl_pkg::EN_RST;
      q.gain_r <= codec_ctl_pkg::GAIN_RST;
      q.bias_r <= codec_ctl_pkg::BIAS_RST;
      q.mode_r <= codec_ctl_pkg::MODE_RST;
      q.pcm_r <= codec_ctl_pkg::PCM_RST;
      q.bit_cnt_r <= '1;  // no frame seen yet, so the pcm output stays released
    end else begin
      q <= n;
    end
  end

  // outputs straight from state
  assign reg_rdata = q.rdata_r;
  assign pcm_serial_out = q.pout_r;
  assign pcm_serial_oe = q.poe_r;
  assign ear_from_codec0 = q.ear0_r;
  assign ear_from_codec1 = q.ear1_r;
  assign mic_to_codec0 = q.mic0_r;
  assign mic_to_codec1 = q.mic1_r;
  // aux tone only with its select bit
  assign aux_tone_input_sel = q.xpt_r[codec_ctl_pkg::XPT_AUX];
  // shared gain field for interface zero and aux tone
  assign loudspeaker_outputs_gain = q.gain_r[codec_ctl_pkg::GAIN_RX0 +: 4];
  // 16 codes cover -39 dB to +6 dB
  assign sidetone_gain = q.gain_r[codec_ctl_pkg::GAIN_SIDE +: 4];
  assign sidetone_on = q.side_r;
  // one bias code drives all four bias output bits
  assign electret_bias_output = q.bias_r;
  assign mic_muted = q.muted_r;
  assign tx_analog_en = q.en_r[codec_ctl_pkg::EN_TX +: 2];
  assign cal_active = {q.cal_r[1] == codec_ctl_pkg::CAL_RUN, q.cal_r[0] == codec_ctl_pkg::CAL_RUN};
  assign vref_power_on = q.en_r[codec_ctl_pkg::EN_VREF];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence latch_event_s;
    q.mode_r[5:4] == codec_ctl_pkg::MM_LATCH && q.filt[0];
  endsequence
  sequence stay_latch_s;
    (q.mode_r[5:4] == codec_ctl_pkg::MM_LATCH) [*3];
  endsequence

  chk_cal_start: assert property ($rose(q.en_r[0]) |=> q.cal_r[0] == codec_ctl_pkg::CAL_RUN)
    else $error("calibration did not start on enable");
  chk_cal_bound: assert property (q.cal_cnt_r[1] <= codec_ctl_pkg::CAL_PULSES)
    else $error("calibration ran past its pulse budget");
  chk_codec_gate: assert property (!q.xpt_r[0] |=> (q.mic0_r == 4'h0 && q.ear0_r == 4'h0))
    else $error("codec 0 routed while disconnected");
  chk_codec0_wins: assert property ((q.mic0_r & q.mic1_r) == 4'h0 && (q.ear0_r & q.ear1_r) == 4'h0)
    else $error("interface shared by both codecs");
  chk_aux_prio: assert property (q.xpt_r[10] |=> !q.ear0_r[0] && !q.ear1_r[0])
    else $error("codec kept loudspeaker while aux tone selected");
  chk_latch_hold: assert property (latch_event_s ##1 stay_latch_s |-> q.muted_r[2])
    else $error("latched mute released without open mode");
  chk_always_mute: assert property (q.mode_r[7:6] == codec_ctl_pkg::MM_ALWAYS |=> q.muted_r[3])
    else $error("mode always-muted left mic open");
  chk_side_blank: assert property (q.muted_r[2] && q.mic0_r == 4'h0 |-> !q.side_r[0])
    else $error("sidetone on with no live mic");
  chk_ssi_release: assert property (q.pcm_r[1:0] == codec_ctl_pkg::FMT_SSI && !q.filt[4]
                                    ##1 q.pcm_r[1:0] == codec_ctl_pkg::FMT_SSI |-> !pcm_serial_oe)
    else $error("pcm output driven outside select window");

endmodule : codec_path_ctl

// *** verification/host_ctl_model.sv ***
// host controller model: register writes and reads on the plain register port
// assumes the block never stalls; signals change right after a rising edge
module host_ctl_model #(
  parameter int SETTLE = 64  // shortened reference settling time in cycles
) (
  input  wire logic        clk_sys,
  output logic      [7:0]  reg_addr,
  output logic      [31:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idle from time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one strobe cycle then one idle cycle, so a strobe is never set twice in a step
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    reg_wr <= w;
    reg_rd <= ~w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clk_sys);
  endtask : acc
  task automatic power_up(input logic [1:0] tx);
    acc(1'b1, 8'h04, 32'h4);
    repeat (SETTLE) @(posedge clk_sys);
    acc(1'b1, 8'h04, {29'h0, 1'b1, tx});
  endtask : power_up
  task automatic reopen(input logic [31:0] mode);
    acc(1'b1, 8'h10, 32'h0);
    acc(1'b1, 8'h10, mode);
  endtask : reopen
endmodule : host_ctl_model

// *** verification/codec_path_control_and_mute_tb.sv ***
// bench for the path control block: host model drives registers, pins driven here
// assumes detect filtering settles within eight cycles
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("Error %0t: got %h exp %h", $time, g, e); end end
module codec_path_control_and_mute_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, rst_n, frame, bclk, sout, vref, reg_wr, reg_rd, rd_d, aux, oe;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d, exp_v, exp_q[$];
  logic [1:0]  det, pres, cal, side, txen;
  logic [3:0]  e0, e1, m0, m1, muted, sg, lg, bias;
  logic [15:0] tw0, tw1;
  logic [16:0] xp_exp[4] = '{17'h04020, 17'h05090, 17'h00202, 17'h00021};
  logic [31:0] xp[4] = '{32'h017, 32'h3B7, 32'h002, 32'h401};
  // codecs with a live mic per cross-point vector, before the sidetone mute
  logic [1:0]  xs[4] = '{2'b01, 2'b11, 2'b10, 2'b01};
  int          fails, tests_run;
  host_ctl_model host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd));
  codec_path_ctl dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mic_detect_input(det), .mic_present_input(pres), .pcm_frame_alignment(frame),
    .pcm_bit_clk(bclk), .tx_word0(tw0), .tx_word1(tw1), .pcm_serial_out(sout),
    .pcm_serial_oe(oe), .ear_from_codec0(e0), .ear_from_codec1(e1), .mic_to_codec0(m0),
    .mic_to_codec1(m1), .aux_tone_input_sel(aux), .loudspeaker_outputs_gain(lg),
    .sidetone_gain(sg), .sidetone_on(side), .electret_bias_output(bias), .mic_muted(muted),
    .tx_analog_en(txen), .cal_active(cal), .vref_power_on(vref));
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wt
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    host.acc(1'b0, a, 32'h0);
  endtask : rd
  // one select window: each bit is looked at just before the next bit clock rise
  task automatic frame_chk(input logic [39:0] e, input int nb);
    frame <= 1'b1;
    wt(8);
    for (int i = 39; i >= 40 - nb; i--) begin
      `CHK({oe, sout}, {1'b1, e[i]})
      bclk <= 1'b1;
      wt(4);
      bclk <= 1'b0;
      wt(4);
    end
    `CHK({oe, sout}, 2'b00)
    frame <= 1'b0;
    wt(8);
  endtask : frame_chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  // read data stands one cycle after the strobe: take the oldest note then
  always @(posedge clk_sys) rd_d <= reg_rd;
  always @(negedge clk_sys) if (rd_d) begin
    exp_v = exp_q.pop_front();
    `CHK(reg_rdata, exp_v)
  end
  // clock and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    wt(6000);
    fails++;
    conclude();
  end
  // main sequence
  initial begin
    void'($urandom(32'hFAC2C6E1));
    {rst_n, frame, bclk, det, pres, fails, tests_run} = '0;
    tw0 = 16'($urandom());
    tw1 = 16'($urandom());
    wt(8);
    rst_n <= 1'b1;
    pres <= 2'b10;
    wt(6);
    foreach (xp[i]) rd(8'h00 + 8'(i * 4), 32'h0);
    rd(8'h1C, 32'h0);
    rd(8'h18, 32'h2);
    `CHK(oe, 1'b0)
    d = $urandom() & 32'hFFFFFF1F;
    host.acc(1'b1, 8'h08, d);
    host.acc(1'b1, 8'h0C, d);
    rd(8'h08, d & 32'hF1F);
    rd(8'h0C, d & 32'hF);
    `CHK({sg, lg, bias}, {d[3:0], d[11:8], d[3:0]})
    $display("test registers done");
    foreach (xp[i]) begin
      host.acc(1'b1, 8'h00, xp[i]);
      wt(2);
      `CHK({e0, e1, m0, m1, aux, side}, {xp_exp[i], xs[i] & {2{~d[4]}}})
    end
    $display("test cross-point done");
    host.acc(1'b1, 8'h10, 32'h10);
    det <= 2'b01;
    wt(8);
    `CHK(muted, 4'h4)
    det <= 2'b00;
    wt(8);
    `CHK(muted, 4'h0)
    host.acc(1'b1, 8'h10, 32'h20);
    wt(6);
    `CHK(muted, 4'h0)
    det <= 2'b01;
    wt(8);
    det <= 2'b00;
    wt(8);
    `CHK(muted, 4'h4)
    rd(8'h18, 32'h12);
    host.reopen(32'h20);
    wt(2);
    `CHK(muted, 4'h0)
    host.acc(1'b1, 8'h10, 32'hC1);
    wt(2);
    `CHK({muted, m0, side}, 10'h240)
    $display("test mute done");
    host.power_up(2'b11);
    `CHK({vref, txen}, 3'b111)
    wt(2);
    repeat (128) begin
      `CHK(cal, 2'b11)
      frame <= 1'b1;
      wt(4);
      frame <= 1'b0;
      wt(4);
    end
    wt(6);
    `CHK(cal, 2'b00)
    $display("test calibration done");
    rst_n <= 1'b0;
    wt(8);
    rst_n <= 1'b1;
    wt(6);
    `CHK({oe, cal, txen, vref, e0, e1, m0, m1}, 22'h000000)
    // milliwatt phase restarts at reset and steps once per frame
    host.acc(1'b1, 8'h14, 32'h12);
    frame_chk({24'h212102, 16'h0000}, 24);
    host.acc(1'b1, 8'h14, 32'h0A);
    frame_chk({tw0, tw1, 8'h02}, 40);
    $display("test pcm done");
    conclude();
  end
endmodule : codec_path_control_and_mute_tb
